//--- logic/mpio_defs.vh
// Purpose: Shared constants for the multiplexed pin I/O port.
// Assumes: Register indices are word indices; byte address is index * 4.
// Notes:   Reset values, pin bit positions and source codes live here.
`ifndef MPIO_DEFS_VH
`define MPIO_DEFS_VH

// Register indices (byte address = index * 4)
`define MPIO_IDX_OUT_ENABLE   8'h44
`define MPIO_IDX_OUT_VALUE    8'h45
`define MPIO_IDX_IN_LEVEL     8'h46
`define MPIO_IDX_SIGNAL_OUT_PIN_CFG   8'h47

// Reset values
`define MPIO_RST_OUT_ENABLE   8'h00
`define MPIO_RST_OUT_VALUE    8'h00
`define MPIO_RST_SIGNAL_OUT_PIN_CFG   8'h00

// Pin bit positions in the enable, value and level registers
`define MPIO_BIT_SIGNAL_IN    7
`define MPIO_BIT_CLOCK_OUT    6
`define MPIO_BIT_HOST_SEL1    5
`define MPIO_BIT_HOST_SEL0    4
`define MPIO_BIT_TEST_CLK     3
`define MPIO_BIT_TEST_MODE    2
`define MPIO_BIT_TEST_DIN     1
`define MPIO_BIT_TEST_DOUT    0
`define MPIO_NUM_TEST_PINS    4

// Signal-out configuration fields
`define MPIO_SIGCFG_SPEED_BIT 7
`define MPIO_SIGCFG_SEL_MSB   3
`define MPIO_SIGCFG_SEL_LSB   0
`define MPIO_SIGCFG_WR_MASK   8'h8f

// Signal-out source codes
`define MPIO_SRC_HIZ_A        4'h0
`define MPIO_SRC_HIZ_B        4'h1
`define MPIO_SRC_LOW          4'h2
`define MPIO_SRC_HIGH         4'h3
`define MPIO_SRC_TX_ENV       4'h4
`define MPIO_SRC_TX_ACT       4'h5
`define MPIO_SRC_SECURE       4'h6
`define MPIO_SRC_RX_ENV       4'h7
`define MPIO_SRC_RX_ACT       4'h8
`define MPIO_SRC_RX_BIT       4'h9

// Clock-out source code that hands the pin to the port
`define MPIO_CLKSRC_IO        4'h0

`endif

//--- logic/mpio_sync.v
// Purpose: Two-stage synchroniser bank for pin input levels.
// Assumes: Inputs are asynchronous pad levels; one destination clock.
// Notes:   First stage feeds only the second stage.
`timescale 1ns/1ps
`default_nettype none

module mpio_sync #(
    parameter WIDTH = 8
) (
    // Clock and reset
    input  wire             i_mclk,
    input  wire             i_rstn,
    // Levels
    input  wire [WIDTH-1:0] i_async,
    output wire [WIDTH-1:0] o_sync
);

    genvar g;

    // One pair of flops per bit
    generate
        for (g = 0; g < WIDTH; g = g + 1) begin : g_bit
            reg meta_ff;
            reg stable_ff;
            always @(posedge i_mclk or negedge i_rstn) begin
                if (!i_rstn) begin
                    meta_ff   <= 1'b0;
                    stable_ff <= 1'b0;
                end else begin
                    meta_ff   <= i_async[g];
                    stable_ff <= meta_ff;
                end
            end
            assign o_sync[g] = stable_ff;
        end
    endgenerate

endmodule

`default_nettype wire

//--- logic/mpio_signal_out_pin_mux.v
// Purpose: Source decoder for the signal-out pin.
// Assumes: Source signals are already synchronous to the system clock.
// Notes:   Codes above the listed ones leave the pin undriven.
`timescale 1ns/1ps
`default_nettype none
`include "mpio_defs.vh"

module mpio_signal_out_pin_mux (
    // Selection
    input  wire [3:0] i_signal_out_source,
    // Internal sources
    input  wire       i_tx_envelope,
    input  wire       i_tx_active,
    input  wire       i_secure_signal,
    input  wire       i_rx_envelope,
    input  wire       i_rx_active,
    input  wire       i_rx_bit,
    // Pin drive
    output reg        o_value,
    output reg        o_enable
);

    // Decode the source code into level and driver enable
    always @* begin
        o_value  = 1'b0;
        o_enable = 1'b1;
        case (i_signal_out_source)
            `MPIO_SRC_HIZ_A: o_enable = 1'b0;
            `MPIO_SRC_HIZ_B: o_enable = 1'b0;
            `MPIO_SRC_LOW:   o_value  = 1'b0;
            `MPIO_SRC_HIGH:  o_value  = 1'b1;
            `MPIO_SRC_TX_ENV: o_value = i_tx_envelope;
            `MPIO_SRC_TX_ACT: o_value = i_tx_active;
            `MPIO_SRC_SECURE: o_value = i_secure_signal;
            `MPIO_SRC_RX_ENV: o_value = i_rx_envelope;
            `MPIO_SRC_RX_ACT: o_value = i_rx_active;
            `MPIO_SRC_RX_BIT: o_value = i_rx_bit;
            default:         o_enable = 1'b0;
        endcase
    end

endmodule

`default_nettype wire

//--- logic/mpio_port.v
// Purpose: Register-controlled general-purpose I/O port for eight pins,
//          plus the signal-out pin source and pad speed configuration.
// Assumes: Avalon-MM slave with byte addresses, 32-bit data, byte lane 0
//          carries the 8-bit registers; pad levels arrive asynchronously.
// Notes:   The clock-out function path bypasses the output flops so the
//          generated clock is not resampled by the 25 MHz system clock.
//          Decode uses address bits 9 to 2, so ADDR_W must stay at 10.
//          Registers are eight bits wide; pins past the eighth stay
//          undriven inputs.
//          Fast pad edges raise peak supply current; leave them off
//          unless the board supply can take it.
//
// Behaviour
// - Enable bit 7 turns on the signal-in pin driver as general I/O.
// - Enable bit 6 makes the clock-out pin general I/O, its clock off.
// - Enable bits 5 and 4 drive host select pins 1 and 0 as I/O.
// - Enable bits 3 to 0 drive the four test port pins as I/O.
// - With boundary scan on, bits 3 to 0 are ignored for the test port.
// - Value bits 7 to 4 give the level on signal-in, clock-out, sel 1/0.
// - Value bits 3 to 0 give the level on the four test port pins.
// - Level bits 7 to 4 read the signal-in, clock-out and select pins.
// - Level bits 3 to 0 read the test port pins and are read-only.
// - Signal-out config has speed bit 7, zero bits 6-4, source bits 3-0.
// - The speed bit selects fast pad edges for the I/O pins.
// - The source field picks hi-Z, low, high or an internal signal.
// - Clock-out source 0 hands the clock-out pin to the port registers.
//
// Added by the designer: register access over Avalon-MM.
`timescale 1ns/1ps
`default_nettype none
`include "mpio_defs.vh"

module mpio_port #(
    parameter NUM_PINS = 8,
    parameter ADDR_W   = 10
) (
    // Clock and reset
    input  wire                i_mclk,
    input  wire                i_rstn,
    // Avalon-MM slave
    input  wire [ADDR_W-1:0]   i_avs_address,
    input  wire                i_avs_read,
    input  wire                i_avs_write,
    input  wire [31:0]         i_avs_writedata,
    input  wire [3:0]          i_avs_byteenable,
    output wire [31:0]         o_avs_readdata,
    output wire                o_avs_waitrequest,
    // General-purpose pins: level in, drive out, drive enable
    input  wire [NUM_PINS-1:0] i_pin_level,
    output wire [NUM_PINS-1:0] o_pin_out,
    output wire [NUM_PINS-1:0] o_pin_oe,
    // Boundary scan configuration and test port drive on data-out pin
    input  wire                i_bscan_enabled,
    input  wire                i_tap_tdo_value,
    input  wire                i_tap_tdo_enable,
    // Clock-out generator
    input  wire [3:0]          i_clock_out_source,
    input  wire                i_clkgen_value,
    input  wire                i_clkgen_enable,
    // Signal-out sources
    input  wire                i_tx_envelope,
    input  wire                i_tx_active,
    input  wire                i_secure_signal,
    input  wire                i_rx_envelope,
    input  wire                i_rx_active,
    input  wire                i_rx_bit,
    // Signal-out pin and pad control
    output wire                o_signal_out_pin,
    output wire                o_signal_out_oe,
    output wire                o_fast_pad_edges
);

    // Software registers
    reg  [7:0]          out_enable_ff;
    reg  [7:0]          out_value_ff;
    reg  [7:0]          signal_out_pin_cfg_ff;
    // Bus state
    reg                 ack_ff;
    reg  [7:0]          rdata_ff;
    reg  [7:0]          nxt_rdata;
    // Registered pad drive
    reg  [NUM_PINS-1:0] drv_out_ff;
    reg  [NUM_PINS-1:0] drv_oe_ff;
    reg                 signal_out_pin_val_ff;
    reg                 signal_out_pin_oe_ff;
    // Combinational helpers
    wire [NUM_PINS-1:0] pin_level_sync;
    wire [NUM_PINS-1:0] nxt_drv_out;
    wire [NUM_PINS-1:0] nxt_drv_oe;
    wire                bus_req;
    wire                bus_done;
    wire [7:0]          reg_index;
    wire                wr_lane0;
    wire [7:0]          wr_byte;
    wire                clk_func_active;
    wire                sig_mux_value;
    wire                sig_mux_enable;
    wire [3:0]          signal_out_source;

    // Named views of the per-pin control bits; the drive selection
    // below reads each pin's wiring against its own name
    wire signal_in_drive_enable    = out_enable_ff[`MPIO_BIT_SIGNAL_IN];
    wire clock_out_drive_enable    = out_enable_ff[`MPIO_BIT_CLOCK_OUT];
    wire host_select1_drive_enable = out_enable_ff[`MPIO_BIT_HOST_SEL1];
    wire host_select0_drive_enable = out_enable_ff[`MPIO_BIT_HOST_SEL0];
    wire signal_in_out_value       = out_value_ff[`MPIO_BIT_SIGNAL_IN];
    wire clock_out_out_value       = out_value_ff[`MPIO_BIT_CLOCK_OUT];
    wire host_select1_out_value    = out_value_ff[`MPIO_BIT_HOST_SEL1];
    wire host_select0_out_value    = out_value_ff[`MPIO_BIT_HOST_SEL0];

    genvar g;

    // Input levels are resampled before software can see them
    // Costs two cycles of read latency but keeps metastability out
    mpio_sync #(
        .WIDTH (NUM_PINS)
    ) u_sync (
        .i_mclk  (i_mclk),
        .i_rstn  (i_rstn),
        .i_async (i_pin_level),
        .o_sync  (pin_level_sync)
    );

    // Bus decode; low address bits are ignored for aligned words
    assign bus_req   = i_avs_read | i_avs_write;
    assign bus_done  = bus_req & ack_ff;
    assign reg_index = i_avs_address[9:2];
    assign wr_lane0  = i_avs_write & bus_done & i_avs_byteenable[0];
    assign wr_byte   = i_avs_writedata[7:0];

    // One wait state: the request is held, then answered on the next cycle
    // Back-to-back requests cost two cycles each, because ack_ff drops
    // again after every completed access
    assign o_avs_waitrequest = bus_req & ~ack_ff;
    assign o_avs_readdata    = {24'h000000, rdata_ff};

    // Acknowledge flop toggles the wait state for each request; read data
    // is captured on the request edge and stands until the next request
    always @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            ack_ff   <= 1'b0;
            rdata_ff <= 8'h00;
        end else begin
            ack_ff <= bus_req & ~ack_ff;
            if (bus_req & ~ack_ff) begin
                rdata_ff <= nxt_rdata;
            end
        end
    end

    // Read multiplexer; unmapped indices read as zero
    // Level reads come from the synchroniser, never from the raw pads
    always @* begin
        nxt_rdata = 8'h00;
        case (reg_index)
            `MPIO_IDX_OUT_ENABLE: nxt_rdata = out_enable_ff;
            `MPIO_IDX_OUT_VALUE:  nxt_rdata = out_value_ff;
            `MPIO_IDX_IN_LEVEL:   nxt_rdata = pin_level_sync;
            `MPIO_IDX_SIGNAL_OUT_PIN_CFG: nxt_rdata = signal_out_pin_cfg_ff;
            default:              nxt_rdata = 8'h00;
        endcase
    end

    // Writable registers; the level register has no write path at all
    // Byte lane 0 must be enabled for any write to land
    always @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            out_enable_ff <= `MPIO_RST_OUT_ENABLE;
            out_value_ff  <= `MPIO_RST_OUT_VALUE;
            signal_out_pin_cfg_ff <= `MPIO_RST_SIGNAL_OUT_PIN_CFG;
        end else if (wr_lane0) begin
            case (reg_index)
                `MPIO_IDX_OUT_ENABLE: begin
                    out_enable_ff <= wr_byte;
                end
                `MPIO_IDX_OUT_VALUE: begin
                    out_value_ff <= wr_byte;
                end
                `MPIO_IDX_SIGNAL_OUT_PIN_CFG: begin
                    // Reserved bits are forced to zero
                    signal_out_pin_cfg_ff <= wr_byte & `MPIO_SIGCFG_WR_MASK;
                end
                default: begin
                    out_value_ff <= out_value_ff;
                end
            endcase
        end
    end

    // Clock-out function owns its pin unless the port claims it
    // The source selector belongs to the clock generator's register
    assign clk_func_active = ~clock_out_drive_enable &
                             (i_clock_out_source != `MPIO_CLKSRC_IO);

    // Per-pin drive selection
    // Test pins yield to the test port whenever boundary scan is on
    generate
        for (g = 0; g < NUM_PINS; g = g + 1) begin : g_pin
            if (g < `MPIO_NUM_TEST_PINS) begin : g_test
                // Test port keeps the pins while boundary scan is on
                wire tap_owned = i_bscan_enabled;
                if (g == `MPIO_BIT_TEST_DOUT) begin : g_dout
                    assign nxt_drv_out[g] = tap_owned ? i_tap_tdo_value :
                                            out_value_ff[g];
                    assign nxt_drv_oe[g]  = tap_owned ? i_tap_tdo_enable :
                                            out_enable_ff[g];
                end else begin : g_tin
                    assign nxt_drv_out[g] = tap_owned ? 1'b0 :
                                            out_value_ff[g];
                    assign nxt_drv_oe[g]  = tap_owned ? 1'b0 :
                                            out_enable_ff[g];
                end
            end else if (g == `MPIO_BIT_CLOCK_OUT) begin : g_clk
                // Source 0 with enable clear leaves an undriven input
                assign nxt_drv_out[g] = clock_out_out_value;
                assign nxt_drv_oe[g]  = clock_out_drive_enable;
            end else if (g == `MPIO_BIT_SIGNAL_IN) begin : g_signal_in_pin
                // Signal-in pad is an input until software claims it
                assign nxt_drv_out[g] = signal_in_out_value;
                assign nxt_drv_oe[g]  = signal_in_drive_enable;
            end else if (g == `MPIO_BIT_HOST_SEL1) begin : g_sel1
                assign nxt_drv_out[g] = host_select1_out_value;
                assign nxt_drv_oe[g]  = host_select1_drive_enable;
            end else if (g == `MPIO_BIT_HOST_SEL0) begin : g_sel0
                assign nxt_drv_out[g] = host_select0_out_value;
                assign nxt_drv_oe[g]  = host_select0_drive_enable;
            end else begin : g_gpio
                // Pins past the eighth have no register bits behind them
                assign nxt_drv_out[g] = 1'b0;
                assign nxt_drv_oe[g]  = 1'b0;
            end
        end
    endgenerate

    // Pad drive flops; one cycle from register write to pin
    // Reset clears every drive flop; only a clock-out pin that the clock generator owns, and with
    // boundary scan on the test data-out pin, can be driven before software has set the port up
    always @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            drv_out_ff <= {NUM_PINS{1'b0}};
            drv_oe_ff  <= {NUM_PINS{1'b0}};
        end else begin
            drv_out_ff <= nxt_drv_out;
            drv_oe_ff  <= nxt_drv_oe;
        end
    end

    // Generated clock goes straight out; resampling it would destroy it
    // Only bit 6 may change without a system clock edge
    generate
        for (g = 0; g < NUM_PINS; g = g + 1) begin : g_drive
            if (g == `MPIO_BIT_CLOCK_OUT) begin : g_clock_output_pin
                assign o_pin_out[g] = clk_func_active ? i_clkgen_value :
                                      drv_out_ff[g];
                assign o_pin_oe[g]  = clk_func_active ? i_clkgen_enable :
                                      drv_oe_ff[g];
            end else begin : g_plain
                assign o_pin_out[g] = drv_out_ff[g];
                assign o_pin_oe[g]  = drv_oe_ff[g];
            end
        end
    endgenerate

    // Signal-out source field
    // Bits 3 to 0 pick the source; the speed bit is decoded apart
    assign signal_out_source =
        signal_out_pin_cfg_ff[`MPIO_SIGCFG_SEL_MSB:`MPIO_SIGCFG_SEL_LSB];

    mpio_signal_out_pin_mux u_signal_out_pin (
        .i_signal_out_source (signal_out_source),
        .i_tx_envelope       (i_tx_envelope),
        .i_tx_active         (i_tx_active),
        .i_secure_signal     (i_secure_signal),
        .i_rx_envelope       (i_rx_envelope),
        .i_rx_active         (i_rx_active),
        .i_rx_bit            (i_rx_bit),
        .o_value             (sig_mux_value),
        .o_enable            (sig_mux_enable)
    );

    // Signal-out drive registered to avoid glitches from the decoder
    // Costs one cycle of latency on every source
    always @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            signal_out_pin_val_ff <= 1'b0;
            signal_out_pin_oe_ff  <= 1'b0;
        end else begin
            signal_out_pin_val_ff <= sig_mux_value;
            signal_out_pin_oe_ff  <= sig_mux_enable;
        end
    end

    assign o_signal_out_pin = signal_out_pin_val_ff;
    assign o_signal_out_oe  = signal_out_pin_oe_ff;

    // Fast edges raise peak supply current when many pins switch at once
    // The bit is passed on as stored; the pad cells do the rest
    assign o_fast_pad_edges = signal_out_pin_cfg_ff[`MPIO_SIGCFG_SPEED_BIT];

endmodule

`default_nettype wire

//--- verification/mpio_monitor.sv
// Purpose: Port checker for the multiplexed pin I/O port.
// Assumes: Registers sit in byte lane 0; an access ends on waitrequest low.
// Notes:   Register state is inferred from completed bus writes only.
`timescale 1ns/1ps
`default_nettype none

module mpio_monitor #(
    parameter NUM_PINS = 8,
    parameter ADDR_W   = 10
) (
    // Clock and reset
    input wire                i_mclk,
    input wire                i_rstn,
    // Register bus
    input wire [ADDR_W-1:0]   i_avs_address,
    input wire                i_avs_read,
    input wire                i_avs_write,
    input wire [31:0]         i_avs_writedata,
    input wire [3:0]          i_avs_byteenable,
    input wire [31:0]         o_avs_readdata,
    input wire                o_avs_waitrequest,
    // Pins and pin control
    input wire [NUM_PINS-1:0] i_pin_level,
    input wire [NUM_PINS-1:0] o_pin_out,
    input wire [NUM_PINS-1:0] o_pin_oe,
    input wire                i_bscan_enabled,
    input wire [3:0]          i_clock_out_source,
    input wire                o_signal_out_pin,
    input wire                o_signal_out_oe,
    input wire                o_fast_pad_edges
);
    // Completed accesses, decoded by register index
    wire       done    = ~o_avs_waitrequest;
    wire [7:0] idx     = i_avs_address[9:2];
    wire       wr_done = i_avs_write & done & i_avs_byteenable[0];
    wire       rd_done = i_avs_read & done;
    wire       wr44    = wr_done && idx == 8'h44;
    wire       wr47    = wr_done && idx == 8'h47;
    logic [NUM_PINS-1:0] lvl_ff;
    logic [2:0]          stab_ff;

    // Cycles the pad levels have held; the synchroniser needs two of them
    always @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            lvl_ff  <= '0;
            stab_ff <= 3'h0;
        end else begin
            lvl_ff <= i_pin_level;
            if (i_pin_level != lvl_ff)
                stab_ff <= 3'h0;
            else if (stab_ff != 3'h7)
                stab_ff <= stab_ff + 3'h1;
        end
    end

    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_rstn);

    property p_signal_in_pin_drive;
        wr44 |-> ##2 o_pin_oe[7] == $past(i_avs_writedata[7], 2);
    endproperty
    a_signal_in_pin_drive: assert property (p_signal_in_pin_drive)
        else $error("signal-in drive enable wrong");
    property p_clk_gpio;
        wr44 && i_avs_writedata[6] |-> ##2 o_pin_oe[6];
    endproperty
    a_clk_gpio: assert property (p_clk_gpio)
        else $error("clock-out pin not driven as I/O");
    property p_bscan_hold;
        i_bscan_enabled && $past(i_bscan_enabled) |-> o_pin_oe[3:1] == 3'h0;
    endproperty
    a_bscan_hold: assert property (p_bscan_hold)
        else $error("test pins driven under boundary scan");
    property p_level_read;
        rd_done && idx == 8'h46 && stab_ff >= 3'h4
            |-> o_avs_readdata[7:0] == i_pin_level;
    endproperty
    a_level_read: assert property (p_level_read)
        else $error("level register differs from pads");
    property p_cfg_zero;
        rd_done && idx == 8'h47
            |-> o_avs_readdata[6:4] == 3'h0 && o_avs_readdata[31:8] == 24'h0;
    endproperty
    a_cfg_zero: assert property (p_cfg_zero)
        else $error("reserved config bits not zero");
    property p_fast_edges;
        wr47 |=> o_fast_pad_edges == $past(i_avs_writedata[7]);
    endproperty
    a_fast_edges: assert property (p_fast_edges)
        else $error("pad speed output wrong");
    property p_sig_fixed;
        wr47 && i_avs_writedata[3:0] < 4'h4 |-> ##2
            o_signal_out_oe == $past(i_avs_writedata[1], 2) &&
            (!o_signal_out_oe || o_signal_out_pin == $past(i_avs_writedata[0], 2));
    endproperty
    a_sig_fixed: assert property (p_sig_fixed)
        else $error("signal-out fixed level wrong");
    property p_clk_release;
        (wr44 && !i_avs_writedata[6] && i_clock_out_source == 4'h0)
            ##1 (i_clock_out_source == 4'h0) [*2] |-> !o_pin_oe[6];
    endproperty
    a_clk_release: assert property (p_clk_release)
        else $error("released clock-out pin still driven");

    c_wr_enable: cover property (wr44);
    c_rd_level: cover property (rd_done && idx == 8'h46);
    c_bscan: cover property (i_bscan_enabled && wr44);
endmodule

bind mpio_port mpio_monitor #(.NUM_PINS(NUM_PINS), .ADDR_W(ADDR_W)) u_mon (
    .i_mclk(i_mclk), .i_rstn(i_rstn), .i_avs_address(i_avs_address),
    .i_avs_read(i_avs_read), .i_avs_write(i_avs_write),
    .i_avs_writedata(i_avs_writedata), .i_avs_byteenable(i_avs_byteenable),
    .o_avs_readdata(o_avs_readdata), .o_avs_waitrequest(o_avs_waitrequest),
    .i_pin_level(i_pin_level), .o_pin_out(o_pin_out), .o_pin_oe(o_pin_oe),
    .i_bscan_enabled(i_bscan_enabled), .i_clock_out_source(i_clock_out_source),
    .o_signal_out_pin(o_signal_out_pin), .o_signal_out_oe(o_signal_out_oe),
    .o_fast_pad_edges(o_fast_pad_edges));
`default_nettype wire

//--- verification/mpio_pad_model.sv
// Purpose: Outside circuit on the eight general-purpose pads.
// Assumes: The port wins any pad that it drives.
// Notes:   Undriven pads take the outside level, which the bench randomises.
`timescale 1ns/1ps
`default_nettype none

module mpio_pad_model (
    // Port drive
    input  wire [7:0] i_pin_out,
    input  wire [7:0] i_pin_oe,
    // Outside drive
    input  wire [7:0] i_ext_drive,
    // Pad levels
    output wire [7:0] o_pin_level
);
    // Resolve each pad from both parties
    assign o_pin_level = (i_pin_oe & i_pin_out) | (~i_pin_oe & i_ext_drive);
endmodule
`default_nettype wire

//--- verification/test_multiplexed_pin_io_port.sv
// Purpose: Self-checking bench for the multiplexed pin I/O port.
// Assumes: One wait cycle per access, but the bus task waits for it anyway.
// Notes:   Random settings are rechecked against an integer model each pass.
`timescale 1ns/1ps
`default_nettype none

module test_multiplexed_pin_io_port;
    logic        clk, rstn, rd, wr, wreq, bscan, tdo_v, tdo_e, cg_v, cg_e;
    logic        so_pin, so_oe, fast;
    logic [9:0]  addr;
    logic [31:0] wdata, rdata, st;
    logic [3:0]  be, csrc;
    logic [5:0]  src;
    logic [7:0]  drv, lvl, pout, poe;
    int          miscompares, check_count, m_en, m_val, m_cfg;

    mpio_port DUT (
        .i_mclk(clk), .i_rstn(rstn), .i_avs_address(addr), .i_avs_read(rd),
        .i_avs_write(wr), .i_avs_writedata(wdata), .i_avs_byteenable(be),
        .o_avs_readdata(rdata), .o_avs_waitrequest(wreq), .i_pin_level(lvl),
        .o_pin_out(pout), .o_pin_oe(poe), .i_bscan_enabled(bscan),
        .i_tap_tdo_value(tdo_v), .i_tap_tdo_enable(tdo_e),
        .i_clock_out_source(csrc), .i_clkgen_value(cg_v),
        .i_clkgen_enable(cg_e), .i_tx_envelope(src[0]), .i_tx_active(src[1]),
        .i_secure_signal(src[2]), .i_rx_envelope(src[3]),
        .i_rx_active(src[4]), .i_rx_bit(src[5]), .o_signal_out_pin(so_pin),
        .o_signal_out_oe(so_oe), .o_fast_pad_edges(fast));
    mpio_pad_model u_pads (
        .i_pin_out(pout), .i_pin_oe(poe), .i_ext_drive(drv),
        .o_pin_level(lvl));

    // 25 MHz system clock
    always #20 clk = ~clk;

    function automatic logic [31:0] xs();
        st = st ^ (st << 13);
        st = st ^ (st >> 17);
        st = st ^ (st << 5);
        return st;
    endfunction

    task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task finish_test;
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // One Avalon access, held until waitrequest is seen low at a rising
    // edge; only the watchdog ends a wait that never finishes
    task bus(input bit w, input logic [7:0] idx, input logic [31:0] d,
             input logic [3:0] b, output logic [31:0] q);
        @(posedge clk);
        rd <= !w; wr <= w; addr <= {idx, 2'b00}; wdata <= d; be <= b;
        do begin
            @(posedge clk);
        end while (wreq !== 1'b0);
        q = rdata;
        rd <= 1'b0;
        wr <= 1'b0;
    endtask

    task rdc(input logic [7:0] idx, input logic [31:0] exp, input string nm);
        logic [31:0] q;
        bus(0, idx, 32'h0, 4'hf, q);
        chk(nm, q, exp);
    endtask

    // Pins, signal-out and readback against the model
    task check_all;
        logic [7:0] eo, ev;
        int code;
        logic se, so;
        eo = m_en[7:0];
        ev = m_val[7:0];
        if (!eo[6] && csrc != 4'h0) begin
            eo[6] = cg_e;
            ev[6] = cg_v;
        end
        if (bscan) begin
            eo[3:1] = 3'h0;
            eo[0] = tdo_e;
            ev[0] = tdo_v;
        end
        code = m_cfg & 15;
        se = code >= 2 && code <= 9;
        so = code == 3 || (code >= 4 && code <= 9 && src[code-4]);
        repeat (4) @(posedge clk);
        @(negedge clk);
        chk("pin oe", poe, eo);
        chk("pin out", pout & eo, ev & eo);
        chk("sig oe", so_oe, se);
        if (se) chk("sig pin", so_pin, so);
        chk("fast", fast, m_cfg[7]);
        rdc(8'h44, m_en, "en");
        rdc(8'h45, m_val, "val");
        rdc(8'h46, (eo & ev) | (~eo & drv), "lvl");
        rdc(8'h47, m_cfg, "cfg");
        rdc(8'h40, 0, "unmapped");
    endtask

    initial begin
        logic [31:0] q, r, e, v;
        clk = 0; rstn = 0; rd = 0; wr = 0; addr = 0; wdata = 0; be = 0;
        drv = 0; bscan = 0; tdo_v = 0; tdo_e = 0; csrc = 0; cg_v = 0;
        cg_e = 0; src = 0; st = 32'h5b6f300c;
        m_en = 0; m_val = 0; m_cfg = 0;
        repeat (6) @(posedge clk);
        rstn <= 1'b1;
        check_all;
        // Every source code in turn with random pins, drives and modes
        for (int i = 0; i < 32; i++) begin
            if (i == 16) begin
                rstn <= 1'b0;
                @(posedge clk);
                rstn <= 1'b1;
                m_en = 0; m_val = 0; m_cfg = 0;
            end
            r = xs();
            @(posedge clk);
            drv <= r[7:0]; bscan <= r[8]; tdo_v <= r[9]; tdo_e <= r[10];
            csrc <= r[11] ? r[15:12] : 4'h0; cg_v <= r[16]; cg_e <= r[17];
            src <= r[23:18];
            e = xs() & 32'hff;
            v = xs() & 32'hff;
            bus(1, 8'h44, e, (i % 5 == 0) ? 4'he : 4'hf, q);
            if (i % 5 != 0) m_en = e;
            bus(1, 8'h45, v, 4'hf, q);
            m_val = v;
            bus(1, 8'h46, r, 4'hf, q);
            bus(1, 8'h40, r, 4'hf, q);
            bus(1, 8'h47, (r & 32'hf0) | (i % 16), 4'hf, q);
            m_cfg = ((r & 32'hf0) | (i % 16)) & 32'h8f;
            check_all;
        end
        finish_test;
    end

    // Watchdog far beyond the expected twelve hundred or so cycles
    initial begin
        repeat (20000) @(posedge clk);
        miscompares++;
        finish_test;
    end
endmodule
`default_nettype wire
